// ===== smlc_top.sv
// Modem line control, loopback, identification and reset logic of the serial card
//
// Notes on behaviour
// [RL1] Drive DTR and RTS; watch DSR, DCD and CTS for handshaking.
// [RL2] Outputs always driven; inputs only judged while handshaking is on.
// [RL3] Card reset or deactivation drops DTR and RTS.
// [RL4] Activation raises DTR, other lines untouched.
// [RL5] Sending raises RTS; with handshaking, hold characters until DSR and CTS high.
// [RL6] With handshaking, drop received characters while DSR or DCD low.
// [RL7] End of outbound block transfer drops RTS.
// [RL8] Modem control bits 0-3 set lines, bit 4 selects loopback.
// [RL9] Bit 3 drives data rate select, bit 2 secondary request-to-send.
// [RL10] A modem control write replaces every bit.
// [RL11] Loopback holds the transmit pin at mark.
// [RL12] Loopback feeds transmitter output into receiver input.
// [RL13] Loopback maps DTR-CTS, RTS-DSR, DRS-DCD, SRTS-RI.
// [RL14] Loopback change events come from the looped control outputs.
// [RL15] Byte registers are eight bits; reads return current, writes store.
// [RL16] Negative control values refused; bits above a byte discarded.
// [RL17] After reset every setting holds its default until rewritten.
// [RL18] Identification returns a fixed code; bit 7 flags removed remote jumper.
// [RL19] Nonzero card reset write resets at once, aborts, discards buffers.
// [RL20] Interrupt state bit 7 enable, bit 6 service request.
// [RL21] Interrupt state bits 5:4 give switch level 3, 4, 5.
// [RL22] Bits 5:4 read 11 for level 6.
// [RL23] Bit 1 drives request-to-send, bit 0 data terminal ready.
// [RL24] Handshake setting 0 disables, 1 enables input line checks.
// [RL25] Peer raises DSR/CTS before data, keeps DSR/DCD while sending.
`timescale 1ns/1ps
module smlc_top #(
  parameter logic [6:0] ID_CODE = smlc_pkg::ID_CODE_DEF
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_resetn,
  // Register access
  input  wire smlc_pkg::smlc_req_s  i_req,
  output logic                      o_rd_valid,
  output smlc_pkg::smlc_byte_t      o_rd_data,
  // Transmit character path
  input  wire logic                 i_tx_valid,
  input  wire smlc_pkg::smlc_byte_t i_tx_data,
  output logic                      o_tx_ready,
  output logic                      o_txq_valid,
  output smlc_pkg::smlc_byte_t      o_txq_data,
  input  wire logic                 i_txq_ready,
  input  wire logic                 i_xfer_end_out,
  // Receive character path
  input  wire logic                 i_rx_valid,
  input  wire smlc_pkg::smlc_byte_t i_rx_data,
  output logic                      o_rx_ready,
  // Serial data
  input  wire logic                 i_uart_txd,
  input  wire logic                 i_rxd,
  output logic                      o_txd,
  output logic                      o_uart_rxd,
  // Modem lines
  output smlc_pkg::smlc_out_s       o_lines,
  input  wire smlc_pkg::smlc_in_s   i_lines,
  // Card straps and interrupt state
  input  wire logic                 i_remote_removed,
  input  wire logic [1:0]           i_irq_level_sw,
  input  wire logic                 i_irq_enabled,
  input  wire logic                 i_irq_pending,
  // Status out
  output logic                      o_modem_change,
  output logic                      o_abort,
  output logic                      o_active,
  output logic                      o_handshake
);
  import smlc_pkg::*;

  // Request decode
  smlc_byte_t wbyte;
  logic       ctl_wr, hw_wr, card_reset, soft_reset;
  logic       wr_mcr, wr_act, wr_hs, activate, deactivate;
  logic       rd_rx, rd_mst;

  assign wbyte      = i_req.wdata[7:0]; // RL16
  assign ctl_wr     = i_req.wr & ~i_req.hw & ~i_req.wdata[15]; // RL16
  assign hw_wr      = i_req.wr & i_req.hw;
  assign card_reset = (ctl_wr && i_req.addr == REG_CARD && wbyte != BYTE_ZERO)
                    || (hw_wr && i_req.addr == HW_ID_RESET); // RL19
  assign wr_mcr     = (ctl_wr && i_req.addr == REG_MODEM_CTRL)
                    || (hw_wr && i_req.addr == HW_MODEM_CTRL);
  assign wr_act     = ctl_wr && i_req.addr == REG_ACTIVE;
  assign wr_hs      = ctl_wr && i_req.addr == REG_HANDSHAKE;
  assign activate   = wr_act && wbyte == VAL_ONE;
  assign deactivate = wr_act && wbyte == BYTE_ZERO;
  assign soft_reset = activate
                    || (ctl_wr && i_req.addr == REG_SOFT_RST && wbyte != BYTE_ZERO);
  assign rd_rx      = i_req.rd & ~i_req.hw & (i_req.addr == REG_RX_DATA);
  assign rd_mst     = i_req.rd & ~i_req.hw & (i_req.addr == REG_MODEM_STAT);

  // Settings
  logic [MCR_W-1:0] mcr_q, mcr_d;
  logic             act_q, act_d;
  logic             hs_q, hs_d;
  logic             abort_q, abort_d;
  logic             tx_take;
  logic             loop;

  assign loop = mcr_q[MCR_LOOP];

  always_comb begin
    mcr_d   = mcr_q;
    act_d   = act_q;
    hs_d    = hs_q;
    abort_d = card_reset;
    if (tx_take) begin
      mcr_d[MCR_RTS] = 1'b1; // RL5
    end
    if (i_xfer_end_out) begin
      mcr_d[MCR_RTS] = 1'b0; // RL7
    end
    if (wr_mcr) begin
      mcr_d = wbyte[MCR_W-1:0]; // RL10
    end
    if (activate) begin
      act_d          = 1'b1;
      mcr_d[MCR_DTR] = 1'b1; // RL4
    end
    if (deactivate) begin
      act_d          = 1'b0;
      mcr_d[MCR_DTR] = 1'b0; // RL3
      mcr_d[MCR_RTS] = 1'b0;
    end
    if (wr_hs && wbyte == BYTE_ZERO) begin
      hs_d = 1'b0; // RL24
    end
    if (wr_hs && wbyte == VAL_ONE) begin
      hs_d = 1'b1; // RL24
    end
    if (card_reset) begin
      mcr_d = MCR_RESET; // RL3
      act_d = ACTIVE_RESET; // RL17
      hs_d  = HS_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      mcr_q   <= MCR_RESET;
      act_q   <= ACTIVE_RESET;
      hs_q    <= HS_RESET;
      abort_q <= 1'b0;
    end else begin
      mcr_q   <= mcr_d;
      act_q   <= act_d;
      hs_q    <= hs_d;
      abort_q <= abort_d;
    end
  end

  // Lines always driven from the control bits
  assign o_lines.dtr  = mcr_q[MCR_DTR];  // RL1 RL2 RL23
  assign o_lines.rts  = mcr_q[MCR_RTS];  // RL23
  assign o_lines.drs  = mcr_q[MCR_DRS];  // RL8 RL9
  assign o_lines.srts = mcr_q[MCR_SRTS]; // RL9
  assign o_active     = act_q;
  assign o_handshake  = hs_q;
  assign o_abort      = abort_q;

  // Effective status lines, looped from the outputs in self-test
  smlc_in_s eff;
  always_comb begin
    eff = i_lines;
    if (loop) begin
      eff.cts = mcr_q[MCR_DTR];  // RL13
      eff.dsr = mcr_q[MCR_RTS];
      eff.dcd = mcr_q[MCR_DRS];
      eff.ri  = mcr_q[MCR_SRTS];
    end
  end

  // Change events follow eff, so loopback changes come from the outputs
  logic [3:0] delta;
  logic [3:0] eff_v;
  assign eff_v = {eff.dcd, eff.ri, eff.dsr, eff.cts};
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_delta
    smlc_delta #(
      .FALL_ONLY (gi == 2)
    ) u_delta (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_level   (eff_v[gi]),
      .i_clear   (rd_mst | card_reset),
      .o_delta   (delta[gi])
    ); // RL14
  end
  assign o_modem_change = |delta;

  // Transmit holding, gated by DSR and CTS when checking is on
  logic tx_gate, tx_full;
  assign tx_gate     = ~hs_q | (eff.dsr & eff.cts); // RL5 RL2
  assign o_txq_valid = tx_full & tx_gate;
  assign tx_take     = i_tx_valid & o_tx_ready & ~card_reset;

  smlc_slot u_tx_slot (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_flush     (card_reset),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (i_tx_data),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (tx_full),
    .o_out_data  (o_txq_data),
    .i_out_ready (i_txq_ready & tx_gate)
  );

  // Receive holding; characters refused by the line check never load
  logic       rx_drop, rx_full;
  smlc_byte_t rx_data;
  assign rx_drop = hs_q & (~eff.dsr | ~eff.dcd); // RL6

  smlc_slot u_rx_slot (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_flush     (card_reset | soft_reset), // RL19
    .i_in_valid  (i_rx_valid & ~rx_drop),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (rx_full),
    .o_out_data  (rx_data),
    .i_out_ready (rd_rx)
  );

  // Serial routing, registered to keep the pin glitch free
  logic txd_q, txd_d, urxd_q, urxd_d;
  always_comb begin
    txd_d  = loop ? 1'b1 : i_uart_txd;       // RL11
    urxd_d = loop ? i_uart_txd : i_rxd;      // RL12
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      txd_q  <= 1'b1;
      urxd_q <= 1'b1;
    end else begin
      txd_q  <= txd_d;
      urxd_q <= urxd_d;
    end
  end
  assign o_txd      = txd_q;
  assign o_uart_rxd = urxd_q;

  // Read answers
  smlc_byte_t rd_q, rd_d, id_b, intr_b;
  logic       rdv_q, rdv_d;
  assign id_b   = {i_remote_removed, ID_CODE}; // RL18
  assign intr_b = {i_irq_enabled, i_irq_pending, i_irq_level_sw, 4'h0}; // RL20 RL21 RL22

  always_comb begin
    rdv_d = i_req.rd;
    rd_d  = BYTE_ZERO;
    if (i_req.hw) begin
      case (i_req.addr)
        HW_ID_RESET:   rd_d = id_b;
        HW_INTR:       rd_d = intr_b;
        HW_MODEM_CTRL: rd_d = {3'h0, mcr_q}; // RL15
        default:       rd_d = BYTE_ZERO;
      endcase
    end else begin
      case (i_req.addr)
        REG_CARD:       rd_d = id_b;
        REG_INTR:       rd_d = intr_b;
        REG_MODEM_CTRL: rd_d = {3'h0, mcr_q};
        REG_RX_DATA:    rd_d = rx_data;
        REG_MODEM_STAT: rd_d = {eff_v, delta};
        REG_ACTIVE:     rd_d = {7'h00, act_q};
        REG_HANDSHAKE:  rd_d = {7'h00, hs_q};
        default:        rd_d = BYTE_ZERO;
      endcase
    end
    if (!i_req.rd) begin
      rd_d = rd_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rd_q  <= BYTE_ZERO;
      rdv_q <= 1'b0;
    end else begin
      rd_q  <= rd_d;
      rdv_q <= rdv_d;
    end
  end
  assign o_rd_data  = rd_q;
  assign o_rd_valid = rdv_q;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  property p_reset_drops;
    card_reset |=> !o_lines.dtr && !o_lines.rts && !o_active && !o_handshake;
  endproperty
  a_reset_drops: assert property (p_reset_drops) else $error("reset left lines up"); // RL3

  property p_activate;
    activate && !card_reset |=> o_lines.dtr && $stable({o_lines.drs, o_lines.srts});
  endproperty
  a_activate: assert property (p_activate) else $error("activate failed DTR"); // RL4

  property p_rts_on_send;
    tx_take && !wr_mcr && !deactivate && !i_xfer_end_out |=> o_lines.rts;
  endproperty
  a_rts_on_send: assert property (p_rts_on_send) else $error("RTS not raised"); // RL5

  property p_tx_hold;
    hs_q && !(eff.dsr && eff.cts) |-> !o_txq_valid;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("char sent without DSR CTS"); // RL5

  property p_rx_drop;
    !rx_full && i_rx_valid && rx_drop |=> !rx_full;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("dropped char stored"); // RL6

  property p_xfer_end;
    i_xfer_end_out && !wr_mcr && !activate |=> !o_lines.rts;
  endproperty
  a_xfer_end: assert property (p_xfer_end) else $error("RTS high after transfer end"); // RL7

  property p_mcr_write;
    wr_mcr && !card_reset && !wr_act |=> mcr_q == $past(wbyte[MCR_W-1:0]);
  endproperty
  a_mcr_write: assert property (p_mcr_write) else $error("control write not whole"); // RL10

  property p_neg_refused;
    i_req.wr && !i_req.hw && i_req.wdata[15] && !tx_take && !i_xfer_end_out
      |=> $stable(mcr_q) && $stable(act_q) && $stable(hs_q);
  endproperty
  a_neg_refused: assert property (p_neg_refused) else $error("negative value taken"); // RL16

  property p_loop_mark;
    loop [*2] |-> o_txd;
  endproperty
  a_loop_mark: assert property (p_loop_mark) else $error("txd not at mark"); // RL11

  property p_loop_route;
    loop |=> o_uart_rxd == $past(i_uart_txd);
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loop data not routed"); // RL12

  property p_loop_status;
    loop |-> eff.cts == o_lines.dtr && eff.dsr == o_lines.rts
          && eff.dcd == o_lines.drs && eff.ri == o_lines.srts;
  endproperty
  a_loop_status: assert property (p_loop_status) else $error("loop status wrong"); // RL13

  property p_id_read;
    i_req.rd && !i_req.hw && i_req.addr == REG_CARD
      |=> o_rd_valid && o_rd_data == {$past(i_remote_removed), ID_CODE};
  endproperty
  a_id_read: assert property (p_id_read) else $error("bad identification"); // RL18

  property p_reset_flush;
    card_reset |=> !rx_full && !tx_full && o_abort;
  endproperty
  a_reset_flush: assert property (p_reset_flush) else $error("buffers kept on reset"); // RL19

  property p_level_read;
    i_req.rd && i_req.hw && i_req.addr == HW_INTR
      |=> o_rd_data[5:4] == $past(i_irq_level_sw) && o_rd_data[7] == $past(i_irq_enabled);
  endproperty
  a_level_read: assert property (p_level_read) else $error("bad interrupt state"); // RL20 RL21

  c_loop_rx:   cover property (loop ##1 o_uart_rxd != o_txd);
  c_held_tx:   cover property (hs_q && tx_full && !tx_gate ##[1:20] o_txq_valid);
  c_rx_drop:   cover property (i_rx_valid && rx_drop);
  c_change:    cover property (rd_mst && |delta ##1 !o_modem_change);
endmodule

// ===== smlc_pkg.sv
// Constants, register map and carrier types for the serial modem line control block
package smlc_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // Status/control register numbers
  localparam logic [4:0] REG_CARD       = 5'h00;
  localparam logic [4:0] REG_INTR       = 5'h01;
  localparam logic [4:0] REG_MODEM_CTRL = 5'h05;
  localparam logic [4:0] REG_RX_DATA    = 5'h06;
  localparam logic [4:0] REG_MODEM_STAT = 5'h0B;
  localparam logic [4:0] REG_ACTIVE     = 5'h0C;
  localparam logic [4:0] REG_HANDSHAKE  = 5'h0D;
  localparam logic [4:0] REG_SOFT_RST   = 5'h0E;

  // Hardware byte register numbers
  localparam logic [4:0] HW_ID_RESET    = 5'h01;
  localparam logic [4:0] HW_INTR        = 5'h03;
  localparam logic [4:0] HW_MODEM_CTRL  = 5'h05;

  // Modem line control fields
  localparam int unsigned MCR_DTR  = 0;
  localparam int unsigned MCR_RTS  = 1;
  localparam int unsigned MCR_SRTS = 2;
  localparam int unsigned MCR_DRS  = 3;
  localparam int unsigned MCR_LOOP = 4;
  localparam int unsigned MCR_W    = 5;

  // Modem status fields
  localparam int unsigned MST_DCD  = 7;
  localparam int unsigned MST_RI   = 6;
  localparam int unsigned MST_DSR  = 5;
  localparam int unsigned MST_CTS  = 4;

  // Interrupt state fields
  localparam int unsigned INT_EN   = 7;
  localparam int unsigned INT_REQ  = 6;
  localparam int unsigned INT_LVL  = 4;

  // Identification
  localparam int unsigned ID_REMOTE_BIT = 7;
  localparam logic [6:0]  ID_CODE_DEF   = 7'h11; // Arbitrary value

  // Reset values
  localparam logic [MCR_W-1:0] MCR_RESET    = 5'h00;
  localparam logic             ACTIVE_RESET = 1'b0;
  localparam logic             HS_RESET     = 1'b0;
  localparam logic [7:0]       BYTE_ZERO    = 8'h00;
  localparam logic [7:0]       VAL_ONE      = 8'h01;

  typedef logic [7:0] smlc_byte_t;

  typedef struct packed {
    logic              hw;
    logic              wr;
    logic              rd;
    logic [4:0]        addr;
    logic signed [15:0] wdata;
  } smlc_req_s;

  typedef struct packed {
    logic dtr;
    logic rts;
    logic drs;
    logic srts;
  } smlc_out_s;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } smlc_in_s;

endpackage

// ===== smlc_delta.sv
// Sticky change detector for one modem status line
`timescale 1ns/1ps
module smlc_delta #(
  parameter bit FALL_ONLY = 1'b0
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // Line and control
  input  wire logic i_level,
  input  wire logic i_clear,
  // Result
  output logic      o_delta
);
  logic prev_q, prev_d;
  logic delta_q, delta_d;
  logic event_w;

  assign event_w = FALL_ONLY ? (prev_q & ~i_level) : (prev_q ^ i_level);

  always_comb begin
    prev_d  = i_level;
    delta_d = delta_q;
    if (i_clear) begin
      delta_d = 1'b0;
    end
    // Set wins so a change during the read-clear is kept
    if (event_w) begin
      delta_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      prev_q  <= 1'b0;
      delta_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      delta_q <= delta_d;
    end
  end

  assign o_delta = delta_q;
endmodule

// ===== smlc_slot.sv
// One-character holding slot with flush
`timescale 1ns/1ps
module smlc_slot (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_flush,
  // Fill side
  input  wire logic               i_in_valid,
  input  wire smlc_pkg::smlc_byte_t i_in_data,
  output logic                    o_in_ready,
  // Drain side
  output logic                    o_out_valid,
  output smlc_pkg::smlc_byte_t    o_out_data,
  input  wire logic               i_out_ready
);
  import smlc_pkg::*;

  logic       full_q, full_d;
  smlc_byte_t data_q, data_d;

  assign o_in_ready = ~full_q | i_out_ready;

  always_comb begin
    full_d = full_q;
    data_d = data_q;
    if (full_q && i_out_ready) begin
      full_d = 1'b0;
    end
    if (i_in_valid && o_in_ready) begin
      full_d = 1'b1;
      data_d = i_in_data;
    end
    // Flush discards even a character arriving this cycle
    if (i_flush) begin
      full_d = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      full_q <= 1'b0;
      data_q <= BYTE_ZERO;
    end else begin
      full_q <= full_d;
      data_q <= data_d;
    end
  end

  assign o_out_valid = full_q;
  assign o_out_data  = data_q;
endmodule

// ===== smlc_modem.sv
// Behavioural modem peer that answers the card's transmit queue and drives status lines
`timescale 1ns/1ps
module smlc_modem (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_resetn,
  // Commanded levels and stall
  input  wire logic                 i_dsr_on,
  input  wire logic                 i_cts_on,
  input  wire logic                 i_dcd_on,
  input  wire logic                 i_stall,
  // Card side
  input  wire logic                 i_txq_valid,
  input  wire smlc_pkg::smlc_byte_t i_txq_data,
  output logic                      o_txq_ready,
  output smlc_pkg::smlc_in_s        o_lines,
  output logic                      o_rxd,
  // Observation
  output smlc_pkg::smlc_byte_t      o_last,
  output logic [7:0]                o_got_cnt
);
  import smlc_pkg::*;
  // Lines move only after an edge, as a real peer would
  always_ff @(posedge i_ref_clk) begin
    o_lines.dsr <= i_dsr_on;
    o_lines.cts <= i_cts_on;
    o_lines.dcd <= i_dcd_on;
    o_lines.ri  <= 1'b0;
  end
  // Stall lets the bench show a slow peer
  assign o_txq_ready = !i_stall;
  // Receive line idles at mark
  assign o_rxd = 1'b1;
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_got_cnt <= 8'h00;
    end else if (i_txq_valid && o_txq_ready) begin
      o_got_cnt <= o_got_cnt + 8'h01;
      o_last    <= i_txq_data;
    end
  end
endmodule

// ===== tb.sv
// Self-checking bench for the modem line control block
`timescale 1ns/1ps
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp); end end
module tb;
  import smlc_pkg::*;
  localparam logic [6:0] ID = 7'h2A; // Arbitrary value
  logic       clk, rstn, tx_valid, xfer_end, rx_valid, uart_txd, remote;
  logic       irq_en, irq_pend, dsr_on, cts_on, dcd_on, stall;
  logic [1:0] lvl;
  smlc_req_s  req;
  smlc_byte_t tx_data, rx_data, rd_data, txq_data, last, v;
  logic       rd_valid, tx_ready, txq_valid, txq_ready, rx_ready, txd, uart_rxd, rxd;
  logic       mchg, abort, active, hs;
  logic [7:0] got;
  smlc_out_s  lines;
  smlc_in_s   mlines;
  int         error_cnt = 0;
  int         checks = 0;

  always #5 clk = ~clk;

  smlc_top #(.ID_CODE(ID)) dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_req(req), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready), .o_txq_valid(txq_valid), .o_txq_data(txq_data),
    .i_txq_ready(txq_ready), .i_xfer_end_out(xfer_end), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_rx_ready(rx_ready), .i_uart_txd(uart_txd), .i_rxd(rxd),
    .o_txd(txd), .o_uart_rxd(uart_rxd), .o_lines(lines), .i_lines(mlines),
    .i_remote_removed(remote), .i_irq_level_sw(lvl), .i_irq_enabled(irq_en),
    .i_irq_pending(irq_pend), .o_modem_change(mchg), .o_abort(abort),
    .o_active(active), .o_handshake(hs));

  smlc_modem peer (
    .i_ref_clk(clk), .i_resetn(rstn), .i_dsr_on(dsr_on), .i_cts_on(cts_on),
    .i_dcd_on(dcd_on), .i_stall(stall), .i_txq_valid(txq_valid), .i_txq_data(txq_data),
    .o_txq_ready(txq_ready), .o_lines(mlines), .o_rxd(rxd), .o_last(last),
    .o_got_cnt(got));

  task automatic report_and_stop;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Idle cycle first so a strobe never drops and rises in one time step
  task automatic wr(input logic hw, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    req = {hw, 1'b1, 1'b0, a, d};
    @(negedge clk);
    req = {hw, 1'b0, 1'b0, a, d};
  endtask

  // Answer is due exactly one cycle after the request edge
  task automatic rd(input logic hw, input logic [4:0] a, output smlc_byte_t r);
    @(negedge clk);
    req = {hw, 1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    req = {hw, 1'b0, 1'b0, a, 16'h0000};
    `CHK(rd_valid, 1'b1)
    r = rd_data;
  endtask

  task automatic rdc(input logic hw, input logic [4:0] a, input smlc_byte_t e);
    smlc_byte_t r;
    rd(hw, a, r);
    `CHK(r, e)
  endtask

  task automatic send_tx(input smlc_byte_t d);
    tx_valid = 1'b1;
    tx_data = d;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  task automatic send_rx(input smlc_byte_t d);
    rx_valid = 1'b1;
    rx_data = d;
    @(negedge clk);
    rx_valid = 1'b0;
  endtask

  task automatic wait_got(input logic [7:0] n);
    int k;
    for (k = 0; k < 20 && got !== n; k++) @(negedge clk);
    if (got !== n) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  initial begin
    clk = 1'b0; rstn = 1'b0; req = '0; tx_valid = 1'b0; tx_data = 8'h00;
    xfer_end = 1'b0; rx_valid = 1'b0; rx_data = 8'h00; uart_txd = 1'b1;
    remote = 1'b0; lvl = 2'h0; irq_en = 1'b0; irq_pend = 1'b0;
    dsr_on = 1'b0; cts_on = 1'b0; dcd_on = 1'b0; stall = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    `CHK(lines, 4'h0)
    `CHK({txd, active, hs}, 3'h4)
    rdc(1'b0, REG_MODEM_CTRL, 8'h00);
    rdc(1'b0, REG_CARD, {1'b0, ID});
    remote = 1'b1;
    rdc(1'b1, HW_ID_RESET, {1'b1, ID});
    remote = 1'b0;
    for (int i = 0; i < 4; i++) begin
      lvl = 2'(i);
      irq_en = lvl[0];
      irq_pend = lvl[1];
      rdc(1'b0, REG_INTR, {lvl[0], lvl[1], lvl, 4'h0});
      rdc(1'b1, HW_INTR, {lvl[0], lvl[1], lvl, 4'h0});
    end
    // Modem control field mapping and full replacement
    wr(1'b0, REG_MODEM_CTRL, 16'h001F);
    `CHK(lines, 4'hF)
    wr(1'b0, REG_MODEM_CTRL, 16'h0003);
    `CHK(lines, 4'hC)
    rdc(1'b0, REG_MODEM_CTRL, 8'h03);
    wr(1'b0, REG_MODEM_CTRL, 16'h0008);
    `CHK(lines, 4'h2)
    wr(1'b0, REG_MODEM_CTRL, 16'h0004);
    `CHK(lines, 4'h1)
    wr(1'b0, REG_MODEM_CTRL, 16'h0102);
    rdc(1'b0, REG_MODEM_CTRL, 8'h02);
    wr(1'b0, REG_MODEM_CTRL, 16'hFF01);
    rdc(1'b0, REG_MODEM_CTRL, 8'h02);
    wr(1'b1, HW_MODEM_CTRL, 16'h0009);
    rdc(1'b1, HW_MODEM_CTRL, 8'h09);
    `CHK(lines, 4'hA)
    // Activation touches DTR only; deactivation drops DTR and RTS
    wr(1'b0, REG_MODEM_CTRL, 16'h0006);
    wr(1'b0, REG_ACTIVE, 16'h0001);
    `CHK(lines, 4'hD)
    rdc(1'b0, REG_ACTIVE, 8'h01);
    wr(1'b0, REG_ACTIVE, 16'h0000);
    `CHK(lines, 4'h1)
    // Transmit held until DSR and CTS, slow peer meanwhile
    wr(1'b0, REG_HANDSHAKE, 16'h0001);
    send_tx(8'hA5);
    `CHK(lines.rts, 1'b1)
    repeat (3) @(negedge clk);
    `CHK(txq_valid, 1'b0)
    stall = 1'b1;
    dsr_on = 1'b1;
    cts_on = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({txq_valid, got}, 9'h100)
    stall = 1'b0;
    wait_got(8'h01);
    `CHK(last, 8'hA5)
    xfer_end = 1'b1;
    @(negedge clk);
    xfer_end = 1'b0;
    `CHK(lines.rts, 1'b0)
    // Received characters dropped while DCD low under handshaking
    send_rx(8'h3C);
    `CHK(rx_ready, 1'b1)
    dcd_on = 1'b1;
    @(negedge clk);
    send_rx(8'h5A);
    `CHK(rx_ready, 1'b0)
    rdc(1'b0, REG_RX_DATA, 8'h5A);
    // Without handshaking the input lines are not judged
    wr(1'b0, REG_HANDSHAKE, 16'h0000);
    dcd_on = 1'b0;
    dsr_on = 1'b0;
    cts_on = 1'b0;
    @(negedge clk);
    send_rx(8'h77);
    `CHK(rx_ready, 1'b0)
    rdc(1'b0, REG_RX_DATA, 8'h77);
    // Soft reset empties the receive slot but keeps the lines
    send_rx(8'h66);
    wr(1'b0, REG_SOFT_RST, 16'h0001);
    `CHK({rx_ready, lines}, 5'h11)
    wr(1'b0, REG_HANDSHAKE, 16'h0002);
    rdc(1'b0, REG_HANDSHAKE, 8'h00);
    // Loopback: mark on TxD, serial and status lines folded back
    rd(1'b0, REG_MODEM_STAT, v);
    uart_txd = 1'b0;
    @(negedge clk);
    `CHK({txd, uart_rxd}, 2'h1)
    wr(1'b0, REG_MODEM_CTRL, 16'h0019);
    @(negedge clk);
    `CHK({txd, uart_rxd}, 2'h2)
    uart_txd = 1'b1;
    @(negedge clk);
    `CHK(uart_rxd, 1'b1)
    `CHK(mchg, 1'b1)
    rd(1'b0, REG_MODEM_STAT, v);
    `CHK(v, 8'h99)
    `CHK(mchg, 1'b0)
    // Secondary line rise then fall: only the fall marks RI
    wr(1'b0, REG_MODEM_CTRL, 16'h0014);
    wr(1'b0, REG_MODEM_CTRL, 16'h0010);
    rd(1'b0, REG_MODEM_STAT, v);
    `CHK(v, 8'h0D)
    wr(1'b0, REG_MODEM_CTRL, 16'h0000);
    // Card reset aborts a held character and clears settings
    wr(1'b0, REG_HANDSHAKE, 16'h0001);
    wr(1'b0, REG_ACTIVE, 16'h0001);
    wr(1'b0, REG_MODEM_CTRL, 16'h0003);
    send_tx(8'hC3);
    `CHK(tx_ready, 1'b0)
    wr(1'b0, REG_CARD, 16'h0000);
    `CHK({lines, abort}, 5'h18)
    wr(1'b0, REG_CARD, 16'h0005);
    `CHK({abort, active, hs, tx_ready}, 4'h9)
    `CHK(lines, 4'h0)
    dsr_on = 1'b1;
    cts_on = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({abort, got}, 9'h001)
    wr(1'b1, HW_MODEM_CTRL, 16'h0003);
    wr(1'b1, HW_ID_RESET, 16'h0000);
    `CHK({abort, lines}, 5'h10)
    rdc(1'b0, REG_MODEM_CTRL, 8'h00);
    report_and_stop();
  end
endmodule
